// ==== dhl_dac_load.sv ====
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module dhl_dac_load import dhl_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [DHL_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DHL_DATA_W-1:0] avs_writedata,
  output logic [DHL_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic link_strobe,
  input wire logic serial_data_in,
  input wire logic msb_first_sel,
  input wire logic serial_select_n,
  input wire logic dac_latch_load,
  input wire logic async_clear_n,
  input wire logic low_byte_enable_n,
  output logic serial_chain_out,
  output logic [DHL_WORD_W-1:0] dac_code,
  output logic dac_cleared
);
  dhl_pin_if #(.N(DHL_PIN_COUNT)) pins ();

  dhl_pin_sync #(.N(DHL_PIN_COUNT), .STROBE_BIT(DHL_PIN_STROBE), .IDLE(DHL_PIN_IDLE)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .pins_async({low_byte_enable_n, async_clear_n, dac_latch_load, serial_select_n,
                 msb_first_sel, serial_data_in, link_strobe}),
    .sync(pins)
  );

  logic serial_mode;
  logic shift_now;
  logic clr_pin;
  logic load_pin;
  logic [2:0] idx;
  logic idx_ok;
  logic req;
  logic wr_acc;
  dhl_bus_e bus_reg;
  dhl_bus_e bus_next;
  logic [DHL_DATA_W-1:0] readdata_reg;
  logic [DHL_DATA_W-1:0] readdata_next;
  logic [DHL_WORD_W-1:0] input_reg;
  logic [DHL_WORD_W-1:0] input_next;
  logic chain_reg;
  logic chain_next;
  logic [DHL_WORD_W-1:0] dac_reg;
  logic [DHL_WORD_W-1:0] dac_next;
  logic cleared_reg;
  logic cleared_next;

  assign serial_mode = ~pins.level[DHL_PIN_SER_N];
  // Byte enables are ignored in serial mode, except low enable picks the clear zero
  assign shift_now = serial_mode & pins.strobe_rise;
  assign clr_pin = ~pins.level[DHL_PIN_CLR_N];
  assign load_pin = pins.level[DHL_PIN_LOAD];
  assign idx = avs_address[DHL_IDX_LSB +: 3];
  assign idx_ok = (avs_address[DHL_IDX_LSB-1:0] == 2'h0);
  assign req = avs_read | avs_write;
  assign wr_acc = avs_write & (bus_reg == DHL_BUS_ACK) & idx_ok;

  // One wait cycle: request seen, then answered on the next edge
  always_comb begin
    bus_next = DHL_BUS_IDLE;
    readdata_next = readdata_reg;
    case (bus_reg)
      DHL_BUS_IDLE: begin
        if (req) begin
          bus_next = DHL_BUS_ACK;
          readdata_next = '0;
          if (avs_read && idx_ok) begin
            case (idx)
              DHL_IDX_INPUT: readdata_next[DHL_WORD_W-1:0] = input_reg;
              DHL_IDX_STATUS: begin
                readdata_next[DHL_WORD_W-1:0] = dac_reg;
                readdata_next[DHL_STAT_SERIAL_BIT] = serial_mode;
                readdata_next[DHL_STAT_CLEARED_BIT] = cleared_reg;
              end
              default: readdata_next = '0;
            endcase
          end
        end
      end
      DHL_BUS_ACK: bus_next = DHL_BUS_IDLE;
      default: bus_next = DHL_BUS_IDLE;
    endcase
  end

  assign avs_waitrequest = req & (bus_reg != DHL_BUS_ACK);
  assign avs_readdata = readdata_reg;

  always_comb begin
    input_next = input_reg;
    chain_next = chain_reg;
    if (shift_now) begin
      if (pins.level[DHL_PIN_MSB_FIRST]) begin
        input_next = {input_reg[DHL_WORD_W-2:0], pins.level[DHL_PIN_SDATA]};
        chain_next = input_reg[DHL_WORD_W-1];
      end else begin
        input_next = {pins.level[DHL_PIN_SDATA], input_reg[DHL_WORD_W-1:1]};
        chain_next = input_reg[0];
      end
    end else if (wr_acc && !serial_mode) begin
      // Each byte stands alone; no write here touches the DAC latch
      if (idx == DHL_IDX_LOW) begin
        input_next[DHL_BYTE_W-1:0] = avs_writedata[DHL_BYTE_W-1:0];
      end else if (idx == DHL_IDX_HIGH) begin
        input_next[DHL_WORD_W-1:DHL_BYTE_W] = avs_writedata[DHL_BYTE_W-1:0];
      end
    end
  end

  // Clear outranks load; it never reaches the input register
  always_comb begin
    dac_next = dac_reg;
    cleared_next = cleared_reg;
    if (clr_pin) begin
      dac_next = pins.level[DHL_PIN_LBE_N] ? DHL_ZERO_BIPOLAR : DHL_ZERO_UNIPOLAR;
      cleared_next = 1'b1;
    end else if (wr_acc && (idx == DHL_IDX_CLR_UNI)) begin
      dac_next = DHL_ZERO_UNIPOLAR;
      cleared_next = 1'b1;
    end else if (wr_acc && (idx == DHL_IDX_CLR_BIP)) begin
      dac_next = DHL_ZERO_BIPOLAR;
      cleared_next = 1'b1;
    end else if (load_pin || (wr_acc && (idx == DHL_IDX_UPD_A || idx == DHL_IDX_UPD_B))) begin
      dac_next = input_reg;
      cleared_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_reg <= DHL_BUS_IDLE;
      readdata_reg <= '0;
      input_reg <= DHL_RESET_WORD;
      chain_reg <= 1'b0;
      dac_reg <= DHL_RESET_WORD;
      cleared_reg <= 1'b0;
    end else begin
      bus_reg <= bus_next;
      readdata_reg <= readdata_next;
      input_reg <= input_next;
      chain_reg <= chain_next;
      dac_reg <= dac_next;
      cleared_reg <= cleared_next;
    end
  end

  assign serial_chain_out = chain_reg;
  assign dac_code = dac_reg;
  assign dac_cleared = cleared_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  load_pin_a: assert property (load_pin && !clr_pin && !wr_acc |=> dac_code == $past(input_reg))
    else $error("latch load did not move input word to DAC");
  bus_update_a: assert property (wr_acc && (idx == DHL_IDX_UPD_A || idx == DHL_IDX_UPD_B)
      && !clr_pin |=> dac_code == $past(input_reg) && !dac_cleared)
    else $error("update write did not load DAC");
  low_byte_a: assert property (wr_acc && idx == DHL_IDX_LOW && !serial_mode |=>
      input_reg[7:0] == $past(avs_writedata[7:0]) && input_reg[15:8] == $past(input_reg[15:8]))
    else $error("low byte write wrong");
  high_byte_a: assert property (wr_acc && idx == DHL_IDX_HIGH && !serial_mode && !load_pin
      && !clr_pin |=> input_reg[15:8] == $past(avs_writedata[7:0]) && $stable(dac_code))
    else $error("high byte write wrong or touched DAC");
  bus_clear_a: assert property (wr_acc && idx == DHL_IDX_CLR_BIP && !clr_pin && !shift_now
      |=> dac_code == DHL_ZERO_BIPOLAR && $stable(input_reg))
    else $error("bipolar clear write wrong");
  clear_data_a: assert property (wr_acc && idx == DHL_IDX_CLR_UNI && !clr_pin |=>
      dac_code == DHL_ZERO_UNIPOLAR)
    else $error("unipolar clear depended on data");
  clear_pin_a: assert property (clr_pin |=> dac_code ==
      ($past(pins.level[DHL_PIN_LBE_N]) ? DHL_ZERO_BIPOLAR : DHL_ZERO_UNIPOLAR))
    else $error("clear pin chose wrong zero");
  clear_keep_a: assert property (clr_pin && !shift_now && !wr_acc |=> $stable(input_reg))
    else $error("clear disturbed input register");
  shift_msb_a: assert property (shift_now && pins.level[DHL_PIN_MSB_FIRST] |=>
      input_reg == {$past(input_reg[14:0]), $past(pins.level[DHL_PIN_SDATA])}
      && serial_chain_out == $past(input_reg[15]))
    else $error("serial shift wrong");
  no_edge_hold_a: assert property (serial_mode && !pins.strobe_rise && !wr_acc |=>
      $stable(input_reg))
    else $error("input register moved without strobe edge");
  bus_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");

  shift_c: cover property (shift_now ##[1:16] shift_now);
  update_c: cover property (wr_acc && idx == DHL_IDX_UPD_A);
  clear_bip_c: cover property (clr_pin && pins.level[DHL_PIN_LBE_N]);
  status_read_c: cover property (avs_read && idx == DHL_IDX_STATUS && !avs_waitrequest);
endmodule

// ==== dhl_dac_load_tb.sv ====
`timescale 1ns/1ps
module dhl_dac_load_tb import dhl_pkg::*;;
  logic clk, resetn, rd, wr, msb, clr_n, lbe_n, wait_r, chain, cleared;
  logic strobe, sdata, sel_n, load;
  logic [4:0] adr;
  logic [31:0] wd, rdat, rdq;
  logic [15:0] code;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  dhl_dac_load i_dut (.clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdq), .avs_waitrequest(wait_r),
    .link_strobe(strobe), .serial_data_in(sdata), .msb_first_sel(msb),
    .serial_select_n(sel_n), .dac_latch_load(load), .async_clear_n(clr_n),
    .low_byte_enable_n(lbe_n), .serial_chain_out(chain), .dac_code(code),
    .dac_cleared(cleared));
  dhl_host_model i_host (.clk(clk), .strobe(strobe), .sdata(sdata), .sel_n(sel_n),
    .load(load));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run needs well under 5000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do @(posedge clk); while (wait_r !== 1'b0);
    rdat = rdq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic put(input logic [2:0] i, input logic [31:0] d);
    bus(1'b1, {i, 2'b00}, d);
  endtask
  task automatic get(input logic [2:0] i, input logic [31:0] e);
    bus(1'b0, {i, 2'b00}, 32'h0);
    cmp(rdat, e);
  endtask
  initial begin
    resetn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h00;
    wd = 32'h0;
    msb = 1'b1;
    clr_n = 1'b1;
    lbe_n = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    get(3'h7, 32'h0);
    get(3'h6, 32'h0);
    $display("test reset done");
    put(3'h0, 32'hffff_ff34);
    put(3'h1, 32'h0000_0012);
    get(3'h6, 32'h1234);
    get(3'h7, 32'h0);
    put(3'h2, 32'hffff_ffff);
    get(3'h7, 32'h1234);
    put(3'h1, 32'h56);
    get(3'h7, 32'h1234);
    put(3'h3, 32'h0);
    get(3'h7, 32'h5634);
    $display("test byte mode done");
    put(3'h4, 32'hffff_ffff);
    get(3'h7, 32'h2_0000);
    put(3'h2, 32'h0);
    get(3'h7, 32'h5634);
    put(3'h5, 32'h0);
    get(3'h7, 32'h2_8000);
    bus(1'b1, 5'h01, 32'h77);
    bus(1'b0, 5'h19, 32'h0);
    cmp(rdat, 32'h0);
    get(3'h6, 32'h5634);
    $display("test bus clear done");
    i_host.send(16'ha5c3, 1'b1);
    get(3'h7, 32'h1_a5c3);
    put(3'h0, 32'h0);
    get(3'h6, 32'ha5c3);
    i_host.send(16'h3c5a, 1'b1);
    cmp({31'h0, chain}, 32'h1);
    get(3'h7, 32'h1_3c5a);
    msb <= 1'b0;
    i_host.send(16'h1234, 1'b0);
    cmp({31'h0, chain}, 32'h0);
    get(3'h7, 32'h1_1234);
    $display("test serial done");
    clr_n <= 1'b0;
    repeat (5) @(posedge clk);
    cmp({16'h0, code}, 32'h0);
    cmp({31'h0, cleared}, 32'h1);
    clr_n <= 1'b1;
    repeat (5) @(posedge clk);
    cmp({16'h0, code}, 32'h1234);
    cmp({31'h0, cleared}, 32'h0);
    lbe_n <= 1'b1;
    @(posedge clk);
    clr_n <= 1'b0;
    repeat (5) @(posedge clk);
    cmp({16'h0, code}, 32'h8000);
    clr_n <= 1'b1;
    repeat (5) @(posedge clk);
    get(3'h6, 32'h1234);
    $display("test clear pin done");
    complete_run();
  end
endmodule

// ==== dhl_host_model.sv ====
`timescale 1ns/1ps
module dhl_host_model (
  input wire logic clk,
  output logic strobe,
  output logic sdata,
  output logic sel_n,
  output logic load
);
  initial begin
    strobe = 1'b0;
    sdata = 1'b0;
    sel_n = 1'b1;
    load = 1'b0;
  end
  // Strobe high 200 ns in a 400 ns period; data moves while strobe is low
  task automatic send(input logic [15:0] w, input logic msb);
    @(posedge clk);
    sel_n <= 1'b0;
    load <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdata <= msb ? w[15-i] : w[i];
      repeat (4) @(posedge clk);
      strobe <= 1'b1;
      repeat (4) @(posedge clk);
      strobe <= 1'b0;
    end
    // Released line flips, so no stale bit can pass
    sdata <= ~sdata;
    repeat (8) @(posedge clk);
    load <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ==== dhl_pin_if.sv ====
`timescale 1ns/1ps
interface dhl_pin_if #(parameter int N = 7);
  logic [N-1:0] level;
  logic strobe_rise;
  modport src (output level, output strobe_rise);
  modport dst (input level, input strobe_rise);
endinterface

// ==== dhl_pin_sync.sv ====
`timescale 1ns/1ps
module dhl_pin_sync import dhl_pkg::*; #(
  parameter int N = DHL_PIN_COUNT,
  parameter int STROBE_BIT = DHL_PIN_STROBE,
  parameter logic [N-1:0] IDLE = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [N-1:0] pins_async,
  dhl_pin_if.src sync
);
  if (STROBE_BIT >= N) begin : g_bad_strobe
    $error("dhl_pin_sync: strobe bit out of range");
  end

  logic [N-1:0] stage1_reg;
  logic [N-1:0] stage2_reg;
  logic strobe_last_reg;
  logic strobe_last_next;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sync
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          stage1_reg[g] <= IDLE[g];
          stage2_reg[g] <= IDLE[g];
        end else begin
          stage1_reg[g] <= pins_async[g];
          stage2_reg[g] <= stage1_reg[g];
        end
      end
    end
  endgenerate

  always_comb begin
    strobe_last_next = stage2_reg[STROBE_BIT];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe_last_reg <= IDLE[STROBE_BIT];
    end else begin
      strobe_last_reg <= strobe_last_next;
    end
  end

  // Edge found only on the settled copy, never on the first stage
  assign sync.level = stage2_reg;
  assign sync.strobe_rise = stage2_reg[STROBE_BIT] & ~strobe_last_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  strobe_edge_once_a: assert property (sync.strobe_rise |=> !sync.strobe_rise)
    else $error("strobe edge held for two cycles");
endmodule

// ==== dhl_pkg.sv ====
package dhl_pkg;
  localparam int DHL_WORD_W = 16;
  localparam int DHL_BYTE_W = 8;
  localparam int DHL_ADDR_W = 5;
  localparam int DHL_DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [2:0] DHL_IDX_LOW = 3'h0;
  localparam logic [2:0] DHL_IDX_HIGH = 3'h1;
  localparam logic [2:0] DHL_IDX_UPD_A = 3'h2;
  localparam logic [2:0] DHL_IDX_UPD_B = 3'h3;
  localparam logic [2:0] DHL_IDX_CLR_UNI = 3'h4;
  localparam logic [2:0] DHL_IDX_CLR_BIP = 3'h5;
  localparam logic [2:0] DHL_IDX_INPUT = 3'h6;
  localparam logic [2:0] DHL_IDX_STATUS = 3'h7;
  localparam int DHL_IDX_LSB = 2;
  localparam int DHL_STAT_SERIAL_BIT = 16;
  localparam int DHL_STAT_CLEARED_BIT = 17;
  localparam logic [15:0] DHL_ZERO_UNIPOLAR = 16'h0000;
  localparam logic [15:0] DHL_ZERO_BIPOLAR = 16'h8000;
  localparam logic [15:0] DHL_RESET_WORD = 16'h0000;
  // Positions of the synchronised pins
  localparam int DHL_PIN_STROBE = 0;
  localparam int DHL_PIN_SDATA = 1;
  localparam int DHL_PIN_MSB_FIRST = 2;
  localparam int DHL_PIN_SER_N = 3;
  localparam int DHL_PIN_LOAD = 4;
  localparam int DHL_PIN_CLR_N = 5;
  localparam int DHL_PIN_LBE_N = 6;
  localparam int DHL_PIN_COUNT = 7;
  // Resting pin levels; select and clear idle high, so reset shows no false clear
  localparam logic [DHL_PIN_COUNT-1:0] DHL_PIN_IDLE = 7'h28;
  typedef enum logic [1:0] {
    DHL_BUS_IDLE = 2'b01,
    DHL_BUS_ACK = 2'b10
  } dhl_bus_e;
endpackage
